// ---- inc/wdog_defines.svh ----
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define WDOG_TRIG_OFS 8'h34
`define WDOG_STAT_OFS 8'h38
`define WDOG_TRIG_RESET 32'h0000_0108
`define WDOG_LIMIT_MSB 7
`define WDOG_LIMIT_LSB 6
`define WDOG_PSEL_MSB 5
`define WDOG_PSEL_LSB 0
`define WDOG_FIXED_ONE_BIT 8
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WDOG_CLK_HZ 40000000
`define WDOG_MS_CYCLES (`WDOG_CLK_HZ / 1000)
`define WDOG_LONG_OPEN_MS 80
`define WDOG_SHORT_OPEN_MS 30
`define WDOG_STEP_MS 16
`define WDOG_SHUTDOWN_COUNT 5
`endif

// ---- inc/wdog_pkg.sv ----
package wdog_pkg;
  // watchdog phases
  typedef enum logic [1:0] {
    WDOG_LONG_OPEN,
    WDOG_WINDOWED,
    WDOG_SHORT_OPEN
  } wdog_phase_t;

  // decoded trigger write
  typedef struct packed {
    logic valid;
    logic short_req;
    logic [5:0] psel;
    logic [1:0] limit;
  } wdog_trig_t;
endpackage : wdog_pkg

// ---- design/wdog_ms_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.svh"

// free-running millisecond tick from the watchdog clock
module wdog_ms_tick #(
  parameter int unsigned CYCLES_PER_MS = `WDOG_MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  output logic tick_o
);
  logic [31:0] cnt_q;

  // one-cycle tick every millisecond while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
    end else if (ce_i) begin
      if (cnt_q == CYCLES_PER_MS - 1) begin
        cnt_q <= 32'h0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign tick_o = ce_i && (cnt_q == CYCLES_PER_MS - 1);
endmodule : wdog_ms_tick
`default_nettype wire

// ---- design/wdog_top.sv ----
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.svh"

module wdog_top #(
  parameter int unsigned CYCLES_PER_MS = `WDOG_MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic por_i,
  input wire logic active_mode_i,
  input wire logic debug_mode_i,
  input wire logic cause_clr_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wdog_reset_o,
  output logic sleep_req_o,
  output logic watchdog_reset_cause_flag_o
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] act_sync_q;
  logic [1:0] dbg_sync_q;
  logic [1:0] clr_sync_q;
  logic [1:0] por_sync_q;
  logic act_prev_q;

  // two stages each; only the second stage feeds logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_sync_q <= 2'h0;
      dbg_sync_q <= 2'h0;
      clr_sync_q <= 2'h0;
    end else if (ce_i) begin
      act_sync_q <= {act_sync_q[0], active_mode_i};
      dbg_sync_q <= {dbg_sync_q[0], debug_mode_i};
      clr_sync_q <= {clr_sync_q[0], cause_clr_i};
    end
  end

  // power-on sync ignores rst_i, else a plain reset would wipe the miss count
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      por_sync_q <= {por_sync_q[0], por_i};
    end
  end

  logic run;
  logic wake;
  assign run = act_sync_q[1] && !dbg_sync_q[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_prev_q <= 1'b0;
    end else if (ce_i) begin
      act_prev_q <= run;
    end
  end
  assign wake = run && !act_prev_q;

  // ---------------------------------------------------------------
  // millisecond tick
  // ---------------------------------------------------------------
  logic tick;
  wdog_ms_tick #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i && run),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic [1:0] limit_q;
  logic [5:0] psel_q;
  logic req;
  wdog_pkg::wdog_trig_t trig;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
    end
  end

  // only full-word writes count as service
  always_comb begin
    trig = '0;
    trig.valid = req && wb_we_i && (wb_adr_i == `WDOG_TRIG_OFS) && (wb_sel_i == 4'hf);
    trig.psel = wb_dat_i[`WDOG_PSEL_MSB:`WDOG_PSEL_LSB];
    trig.limit = wb_dat_i[`WDOG_LIMIT_MSB:`WDOG_LIMIT_LSB];
    trig.short_req = (trig.psel == 6'h00);
  end

  logic svc;
  assign svc = trig.valid && run && ce_i;

  // stored configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_q <= 2'(`WDOG_TRIG_RESET >> `WDOG_LIMIT_LSB);
      psel_q <= 6'(`WDOG_TRIG_RESET);
    end else if (svc) begin
      limit_q <= trig.limit;
      psel_q <= trig.psel;
    end
  end

  // ---------------------------------------------------------------
  // phase and period timer
  // ---------------------------------------------------------------
  wdog_pkg::wdog_phase_t phase_q;
  logic [9:0] ms_q;
  logic [9:0] len_q;
  logic [1:0] short_cnt_q;
  logic fire;
  logic closed;

  // period length in ms for a selection
  function automatic logic [9:0] period_ms(input logic [5:0] sel);
    period_ms = 10'(sel * `WDOG_STEP_MS);
  endfunction : period_ms

  assign closed = (phase_q == wdog_pkg::WDOG_WINDOWED) && ({ms_q, 1'b0} < {1'b0, len_q});

  // violation decode, combinational on the service and tick
  always_comb begin
    fire = 1'b0;
    if (run && ce_i) begin
      if (svc && trig.short_req) begin
        if (phase_q == wdog_pkg::WDOG_LONG_OPEN || {1'b0, short_cnt_q} >= {1'b0, trig.limit}) begin
          fire = 1'b1;
        end
      end else if (svc) begin
        fire = closed;
      end else if (tick && ms_q + 10'h1 >= len_q) begin
        fire = 1'b1;
      end
    end
  end

  // phase progression
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= wdog_pkg::WDOG_LONG_OPEN;
      ms_q <= 10'h0;
      len_q <= 10'(`WDOG_LONG_OPEN_MS);
    end else if (ce_i) begin
      if (wake || fire) begin
        phase_q <= wdog_pkg::WDOG_LONG_OPEN;
        ms_q <= 10'h0;
        len_q <= 10'(`WDOG_LONG_OPEN_MS);
      end else if (svc && trig.short_req) begin
        phase_q <= wdog_pkg::WDOG_SHORT_OPEN;
        ms_q <= 10'h0;
        len_q <= 10'(`WDOG_SHORT_OPEN_MS);
      end else if (svc) begin
        phase_q <= wdog_pkg::WDOG_WINDOWED;
        ms_q <= 10'h0;
        len_q <= period_ms(trig.psel);
      end else if (run && tick) begin
        ms_q <= ms_q + 10'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      short_cnt_q <= 2'h0;
    end else if (ce_i) begin
      if (wake || fire) begin
        short_cnt_q <= 2'h0;
      end else if (svc && trig.short_req) begin
        short_cnt_q <= short_cnt_q + 2'h1;
      end else if (svc) begin
        short_cnt_q <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // reset output, cause flag, miss counter
  // ---------------------------------------------------------------
  logic [2:0] miss_q;
  logic cause_q;
  logic rst_q;

  // registered reset pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_q <= 1'b0;
    end else if (ce_i) begin
      rst_q <= fire && (miss_q < 3'(`WDOG_SHUTDOWN_COUNT - 1));
    end
  end
  assign wdog_reset_o = rst_q;

  // the miss count and cause flag survive rst_i; of the two resets, only power-on clears them
  always_ff @(posedge clk_i) begin
    if (por_sync_q[1]) begin
      miss_q <= 3'h0;
      cause_q <= 1'b0;
    end else if (ce_i) begin
      if (fire) begin
        cause_q <= 1'b1;
      end else if (clr_sync_q[1]) begin
        cause_q <= 1'b0;
      end
      if (fire && miss_q < 3'(`WDOG_SHUTDOWN_COUNT)) begin
        miss_q <= miss_q + 3'h1;
      end else if (svc && !fire && !trig.short_req) begin
        miss_q <= 3'h0;
      end
    end
  end
  assign sleep_req_o = (miss_q == 3'(`WDOG_SHUTDOWN_COUNT));
  assign watchdog_reset_cause_flag_o = cause_q;

  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      if (req && !wb_we_i && wb_adr_i == `WDOG_TRIG_OFS) begin
        wb_dat_o <= {23'h0, 1'b1, limit_q, psel_q};
      end else if (req && !wb_we_i && wb_adr_i == `WDOG_STAT_OFS) begin
        wb_dat_o <= {16'h0, ms_q, cause_q, miss_q, short_cnt_q};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence short_write_s;
    svc && trig.short_req && phase_q == wdog_pkg::WDOG_LONG_OPEN;
  endsequence

  long_short_a: assert property (@(posedge clk_i) disable iff (rst_i)
    short_write_s |-> fire) else $error("short request in long window not refused");
  halt_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !run |=> $stable(ms_q) && !wdog_reset_o) else $error("watchdog moved while halted");
  period_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && svc && !fire && !wake && !trig.short_req |=> ms_q == 10'h0 && len_q == period_ms($past(trig.psel)))
    else $error("period not loaded");
  short_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && svc && trig.short_req && !fire && !wake |=> len_q == 10'(`WDOG_SHORT_OPEN_MS))
    else $error("short window length wrong");
  closed_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    svc && !trig.short_req && closed |-> fire) else $error("closed service missed");
  cause_set_a: assert property (@(posedge clk_i) disable iff (por_sync_q[1])
    ce_i && fire |=> cause_q) else $error("cause flag not set");
  count_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && svc && !trig.short_req && !fire && !wake |=> short_cnt_q == 2'h0)
    else $error("short counter not cleared");
  wake_long_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wake |=> phase_q == wdog_pkg::WDOG_LONG_OPEN && ms_q == 10'h0)
    else $error("wake did not reinit");
endmodule : wdog_top
`default_nettype wire

// ---- verification/tb_windowed_watchdog.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.svh"

module tb_windowed_watchdog;
  typedef struct packed {logic [31:0] d; logic [31:0] rb;} wdog_row_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, por = 1'b1;
  logic act = 1'b1, dbg = 1'b0, cclr = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic ack, wres, slp, cause;
  int mismatches = 0, checks_done = 0, nres = 0, n0;
  // service rows: written word, expected read-back
  wdog_row_t rows [4] = '{'{32'h41, 32'h141}, '{32'h82, 32'h182},
                          '{32'hc3, 32'h1c3}, '{32'h3f, 32'h13f}};

  // short sim ms so an 80 ms window is 320 cycles
  wdog_top #(.CYCLES_PER_MS(4)) DUT (.clk_i(clk), .rst_i(rst), .ce_i(ce), .por_i(por),
    .active_mode_i(act), .debug_mode_i(dbg), .cause_clr_i(cclr), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wdog_reset_o(wres), .sleep_req_o(slp),
    .watchdog_reset_cause_flag_o(cause));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // count watchdog reset pulses
  always @(posedge clk) begin
    if (wres === 1'b1) nres <= nres + 1;
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task wrap_up;
    $display("mismatches %0d, checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy

  // one classic cycle; no ack latency assumed, only the hang guard bounds the wait
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    // ack must stand for one cycle only
    chk({31'h0, ack}, 32'h0);
  endtask : bus

  task wr(input logic [31:0] d);
    bus(1'b1, `WDOG_TRIG_OFS, d, 4'hf);
  endtask : wr

  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  // tick is free running, so expiry is judged within a margin
  task gap(input int lo, input int hi);
    n0 = nres;
    cy(lo);
    chk(nres, n0);
    cy(hi);
    chk(nres, n0 + 1);
  endtask : gap

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    cy(3);
    rst <= 1'b0;
    por <= 1'b0;
    cy(1);
    rd(`WDOG_TRIG_OFS);
    chk(q, `WDOG_TRIG_RESET);
    rd(8'h3c);
    chk(q, 32'h0);
    // partial-word write must not land
    bus(1'b1, `WDOG_TRIG_OFS, 32'hc1, 4'h3);
    rd(`WDOG_TRIG_OFS);
    chk(q, `WDOG_TRIG_RESET);
    rd(`WDOG_STAT_OFS);
    chk({26'h0, q[5:0]}, 32'h0);
    for (int r = 0; r < 4; r++) begin
      n0 = nres;
      wr(rows[r].d);
      rd(`WDOG_TRIG_OFS);
      chk(q, rows[r].rb);
      if (r < 3) begin
        // service at three quarters, clear of both window edges
        cy(rows[r].d[5:0] * 48);
        chk(nres, n0);
      end
    end
    gap(4020, 24);
    chk({31'h0, cause}, 32'h1);
    cclr <= 1'b1;
    cy(4);
    cclr <= 1'b0;
    cy(4);
    chk({31'h0, cause}, 32'h0);
    n0 = nres;
    wr(32'hc0);
    cy(4);
    chk(nres, n0 + 1);
    n0 = nres;
    wr(32'h02);
    cy(40);
    chk(nres, n0);
    wr(32'h02);
    cy(4);
    chk(nres, n0 + 1);
    // every limit code, one past the limit resets
    for (int l = 0; l < 4; l++) begin
      wr(32'h01);
      cy(10);
      n0 = nres;
      for (int k = 0; k <= l; k++) begin
        wr({24'h0, 2'(l), 6'h00});
        cy(4);
        chk(nres, n0 + (k == l));
      end
    end
    n0 = nres;
    wr(32'h41);
    cy(10);
    wr(32'h40);
    cy(20);
    wr(32'h41);
    cy(48);
    wr(32'h40);
    chk(nres, n0);
    gap(108, 24);
    // debug then low power: frozen, then fresh long window
    for (int m = 0; m < 2; m++) begin
      if (m == 0) dbg <= 1'b1;
      else act <= 1'b0;
      n0 = nres;
      cy(500);
      chk(nres, n0);
      dbg <= 1'b0;
      act <= 1'b1;
      gap(300, 40);
    end
    // clock enable low freezes the window count and the reset pulse
    ce <= 1'b0;
    n0 = nres;
    cy(500);
    chk(nres, n0);
    ce <= 1'b1;
    gap(280, 40);
    rst <= 1'b1;
    por <= 1'b1;
    cy(3);
    rst <= 1'b0;
    por <= 1'b0;
    cy(1);
    gap(300, 40);
    rd(`WDOG_STAT_OFS);
    chk({29'h0, q[4:2]}, 32'h1);
    wr(32'h01);
    rd(`WDOG_STAT_OFS);
    chk({29'h0, q[4:2]}, 32'h0);
    cy(80);
    repeat (3) cy(330);
    chk({31'h0, slp}, 32'h0);
    cy(330);
    chk({31'h0, slp}, 32'h1);
    // a plain reset must leave the miss count and the cause flag alone
    rst <= 1'b1;
    cy(3);
    rst <= 1'b0;
    cy(1);
    rd(`WDOG_STAT_OFS);
    chk({29'h0, q[4:2]}, 32'(`WDOG_SHUTDOWN_COUNT));
    chk({31'h0, cause}, 32'h1);
    wrap_up;
  end

  // hang guard, well beyond the ~9000 cycles needed
  initial begin
    cy(20000);
    mismatches++;
    wrap_up;
  end
endmodule : tb_windowed_watchdog
`default_nettype wire
